// ### verilog/crs_defines.svh
// constants for the cpu register set and stack block
// Functional notes
// - 8-bit accumulator feeds alu operands and takes alu results
// - second index register is never pushed or popped by interrupts
// - 16-bit program counter made of low and high byte halves
// - 8-bit condition code resets to 111x1xxx, pushable and poppable whole
// - half carry bit 4 follows carry from bit 3 on add and adc
// - mask bit 3 set on entry or mask-set, cleared by unmask, restored from the stacked cc by interrupt return
// - requests arriving while masked stay pending until mask clears
// - clearing mask inside a routine lets pending requests in at once
// - zero bit 1 set when last result is zero, cleared otherwise
// - carry bit 0 from arithmetic, set/clear instructions, bit test, shifts
// - 16-bit stack pointer points at next free location, resets to 01ffh
// - stack pointer decrements after a push, increments before a pop
// - upper 9 bits fixed; reset or stack reset sets low seven bits
// - stack pointer low byte readable and writable by load
// - stack pointer wraps silently at both stack limits
// - interrupt entry writes program counter low first at current pointer
// - a call uses two stack bytes, an interrupt five
`ifndef CRS_DEFINES_SVH
`define CRS_DEFINES_SVH
`define CRS_CC_H_BIT      4
`define CRS_CC_I_BIT      3
`define CRS_CC_N_BIT      2
`define CRS_CC_Z_BIT      1
`define CRS_CC_C_BIT      0
`define CRS_CC_RESET      8'he8
`define CRS_SP_HI_FIXED   9'h003
`define CRS_SP_LOW_TOP    7'h7f
`define CRS_SP_RESET      16'h01ff
`define CRS_PC_RESET      16'h0000
`define CRS_CALL_BYTES    3'h2
`define CRS_INT_BYTES     3'h5
`endif

// ### verilog/crs_pkg.sv
// types for the cpu register set and stack block
package crs_pkg;
    // stack operation requested by the sequencer
    typedef enum logic [2:0] {
        CRS_OP_NONE, CRS_OP_PUSH_BYTE, CRS_OP_POP_BYTE, CRS_OP_CALL,
        CRS_OP_RET, CRS_OP_INT, CRS_OP_INTERRUPT_RETURN_INSTR
    } crs_stack_op_t;
    // register selector for loads, pushes and pops
    typedef enum logic [2:0] {
        CRS_SEL_A, CRS_SEL_X, CRS_SEL_Y, CRS_SEL_CC, CRS_SEL_SPL, CRS_SEL_PCL, CRS_SEL_PCH
    } crs_sel_t;
    // alu result with flag update enables
    typedef struct packed {
        logic       valid;
        logic [7:0] result;
        logic       upd_h;
        logic       half;
        logic       upd_c;
        logic       carry;
        logic       upd_nz;
        logic       wr_acc;
    } crs_alu_res_t;
    // stack memory write/read port
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } crs_mem_req_t;
endpackage

// ### verilog/crs_stack_ptr.sv
// stack pointer with fixed upper bits and silent wrap
`timescale 1ns/1ps
`include "crs_defines.svh"
module crs_stack_ptr
    import crs_pkg::*;
#(
    parameter int LOW_BITS = 7
) (
    // clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_sys_rst,
    // control
    input  wire logic              i_dec,
    input  wire logic              i_inc,
    input  wire logic              i_reset_top,
    input  wire logic              i_load,
    input  wire logic [7:0]        i_load_val,
    // pointer
    output logic      [15:0]       o_sp
);
    // only a 128-byte stack is served
    if (LOW_BITS != 7) begin : g_bad_width
        $error("crs_stack_ptr serves a 128-byte stack only");
    end

    logic [6:0] low_reg;

    // low seven bits move; wrap falls out of the modulo count
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            low_reg <= `CRS_SP_LOW_TOP;
        end else if (i_reset_top) begin
            low_reg <= `CRS_SP_LOW_TOP;
        end else if (i_load) begin
            low_reg <= i_load_val[6:0];
        end else if (i_dec) begin
            low_reg <= low_reg - 7'h01;
        end else if (i_inc) begin
            low_reg <= low_reg + 7'h01;
        end
    end

    // upper nine bits are hardwired
    assign o_sp = {`CRS_SP_HI_FIXED, low_reg};
endmodule // crs_stack_ptr

// ### verilog/crs_register_set.sv
// cpu programmer-visible registers, flags and stack sequencing
`timescale 1ns/1ps
`include "crs_defines.svh"
module crs_register_set
    import crs_pkg::*;
(
    // clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_sys_rst,
    // alu result path
    input  wire crs_alu_res_t      i_alu,
    // register loads
    input  wire logic              i_load,
    input  wire crs_sel_t          i_load_sel,
    input  wire logic [7:0]        i_load_val,
    input  wire logic              i_pc_load,
    input  wire logic [15:0]       i_pc_val,
    input  wire logic              i_pc_inc,
    // flag instructions
    input  wire logic              i_mask_set,
    input  wire logic              i_unmask,
    input  wire logic              i_carry_set,
    input  wire logic              i_carry_clear,
    input  wire logic              i_sp_reset,
    // stack operations
    input  wire crs_stack_op_t     i_stack_op,
    input  wire crs_sel_t          i_stack_sel,
    input  wire logic [15:0]       i_call_target,
    input  wire logic [7:0]        i_mem_rdata,
    // interrupt requests
    input  wire logic              i_irq,
    input  wire logic              i_trap,
    // register views
    output logic      [7:0]        o_accumulator,
    output logic      [7:0]        o_index_x,
    output logic      [7:0]        o_index_y,
    output logic      [15:0]       o_program_counter,
    output logic      [7:0]        o_condition_code,
    output logic      [15:0]       o_stack_pointer,
    // stack memory port
    output crs_mem_req_t           o_mem,
    // sequencer status
    output logic                   o_busy,
    output logic                   o_irq_take,
    output logic                   o_irq_pending
);
    typedef enum logic [1:0] {CRS_ST_IDLE, CRS_ST_PUSH, CRS_ST_POP} crs_state_t;

    logic [7:0]   acc_reg;
    logic [7:0]   x_reg;
    logic [7:0]   y_reg;
    logic [15:0]  pc_reg;
    logic [7:0]   cc_reg;
    logic         pend_reg;
    crs_state_t   state_reg;
    logic [2:0]   cnt_reg;
    logic [2:0]   len_reg;
    logic         is_int_reg;
    logic         pop_wait_reg;
    logic [15:0]  ret_pc_reg;
    logic [15:0]  sp;
    logic         sp_dec;
    logic         sp_inc;
    logic         sp_load;
    logic         start_push;
    logic         start_pop;
    logic         pop_single;
    logic         pop_strobe;
    logic         take_irq;
    crs_sel_t     pop_sel;
    crs_sel_t     push_sel;
    logic [7:0]   push_data;

    crs_stack_ptr #(.LOW_BITS(7)) u_sp (
        .i_clk       (i_clk),
        .i_sys_rst   (i_sys_rst),
        .i_dec       (sp_dec),
        .i_inc       (sp_inc),
        .i_reset_top (i_sp_reset),
        .i_load      (sp_load),
        .i_load_val  (i_load_val),
        .o_sp        (sp)
    );

    // an irq is taken only between sequences and when unmasked, trap ignores mask
    assign take_irq   = (state_reg == CRS_ST_IDLE) && (i_stack_op == CRS_OP_NONE)
                        && ((pend_reg && !cc_reg[`CRS_CC_I_BIT]) || i_trap);
    assign start_push = (state_reg == CRS_ST_IDLE)
                        && ((i_stack_op == CRS_OP_CALL) || (i_stack_op == CRS_OP_INT) || take_irq);
    assign start_pop  = (state_reg == CRS_ST_IDLE)
                        && ((i_stack_op == CRS_OP_RET) || (i_stack_op == CRS_OP_INTERRUPT_RETURN_INSTR));
    assign pop_single = (state_reg == CRS_ST_IDLE) && (i_stack_op == CRS_OP_POP_BYTE);
    assign sp_load    = i_load && (i_load_sel == CRS_SEL_SPL);

    // push order pcl, pch, x, a, cc; y never included
    always_comb begin
        case (cnt_reg)
            3'h0:    push_sel = CRS_SEL_PCL;
            3'h1:    push_sel = CRS_SEL_PCH;
            3'h2:    push_sel = CRS_SEL_X;
            3'h3:    push_sel = CRS_SEL_A;
            default: push_sel = CRS_SEL_CC;
        endcase
    end

    // pops walk the same order backwards
    always_comb begin
        if (state_reg == CRS_ST_POP) begin
            case (len_reg - cnt_reg)
                3'h1:    pop_sel = CRS_SEL_PCL;
                3'h2:    pop_sel = CRS_SEL_PCH;
                3'h3:    pop_sel = CRS_SEL_X;
                3'h4:    pop_sel = CRS_SEL_A;
                default: pop_sel = CRS_SEL_CC;
            endcase
        end else begin
            pop_sel = i_stack_sel;
        end
    end

    // data for the byte being pushed
    always_comb begin
        if (state_reg == CRS_ST_PUSH) begin
            case (push_sel)
                CRS_SEL_PCL: push_data = ret_pc_reg[7:0];
                CRS_SEL_PCH: push_data = ret_pc_reg[15:8];
                CRS_SEL_X:   push_data = x_reg;
                CRS_SEL_A:   push_data = acc_reg;
                default:     push_data = cc_reg;
            endcase
        end else begin
            case (i_stack_sel)
                CRS_SEL_A:  push_data = acc_reg;
                CRS_SEL_X:  push_data = x_reg;
                CRS_SEL_Y:  push_data = y_reg;
                default:    push_data = cc_reg;
            endcase
        end
    end

    // write at current pointer then decrement; increment then read
    assign sp_dec     = (state_reg == CRS_ST_PUSH)
                        || ((state_reg == CRS_ST_IDLE) && (i_stack_op == CRS_OP_PUSH_BYTE));
    assign sp_inc     = ((state_reg == CRS_ST_POP) && !pop_wait_reg) || pop_single;
    assign pop_strobe = pop_wait_reg;
    assign o_mem.wr    = sp_dec;
    assign o_mem.rd    = pop_strobe;
    assign o_mem.addr  = sp;
    assign o_mem.wdata = push_data;

    // sequence control: push moves one byte per cycle, pop one byte per two cycles (increment, then read)
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_reg    <= CRS_ST_IDLE;
            cnt_reg      <= 3'h0;
            len_reg      <= 3'h0;
            is_int_reg   <= 1'b0;
            pop_wait_reg <= 1'b0;
        end else begin
            case (state_reg)
                CRS_ST_IDLE: begin
                    cnt_reg      <= 3'h0;
                    pop_wait_reg <= pop_single;
                    if (start_push) begin
                        state_reg  <= CRS_ST_PUSH;
                        is_int_reg <= (i_stack_op != CRS_OP_CALL);
                        len_reg    <= (i_stack_op == CRS_OP_CALL) ? `CRS_CALL_BYTES : `CRS_INT_BYTES;
                    end else if (start_pop) begin
                        state_reg  <= CRS_ST_POP;
                        is_int_reg <= (i_stack_op == CRS_OP_INTERRUPT_RETURN_INSTR);
                        len_reg    <= (i_stack_op == CRS_OP_RET) ? `CRS_CALL_BYTES : `CRS_INT_BYTES;
                    end
                end
                CRS_ST_PUSH: begin
                    cnt_reg <= cnt_reg + 3'h1;
                    if (cnt_reg == len_reg - 3'h1) begin
                        state_reg <= CRS_ST_IDLE;
                    end
                end
                default: begin
                    pop_wait_reg <= !pop_wait_reg;
                    if (pop_wait_reg) begin
                        cnt_reg <= cnt_reg + 3'h1;
                        if (cnt_reg == len_reg - 3'h1) begin
                            state_reg    <= CRS_ST_IDLE;
                            pop_wait_reg <= 1'b0;
                        end
                    end
                end
            endcase
        end
    end

    // return address captured at the start of a push sequence
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ret_pc_reg <= `CRS_PC_RESET;
        end else if (start_push) begin
            ret_pc_reg <= pc_reg;
        end
    end

    // accumulator, alu result or load or pop
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            acc_reg <= 8'h00;
        end else if (pop_strobe && pop_sel == CRS_SEL_A) begin
            acc_reg <= i_mem_rdata;
        end else if (i_alu.valid && i_alu.wr_acc) begin
            acc_reg <= i_alu.result;
        end else if (i_load && i_load_sel == CRS_SEL_A) begin
            acc_reg <= i_load_val;
        end
    end

    // index registers; y only by explicit pop or load
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            x_reg <= 8'h00;
            y_reg <= 8'h00;
        end else begin
            if (pop_strobe && pop_sel == CRS_SEL_X) begin
                x_reg <= i_mem_rdata;
            end else if (i_load && i_load_sel == CRS_SEL_X) begin
                x_reg <= i_load_val;
            end
            if (pop_strobe && pop_sel == CRS_SEL_Y && state_reg == CRS_ST_IDLE) begin
                y_reg <= i_mem_rdata;
            end else if (i_load && i_load_sel == CRS_SEL_Y) begin
                y_reg <= i_load_val;
            end
        end
    end

    // program counter halves; call jumps as the push starts, before the return address is stacked
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pc_reg <= `CRS_PC_RESET;
        end else if (pop_strobe && pop_sel == CRS_SEL_PCL) begin
            pc_reg[7:0] <= i_mem_rdata;
        end else if (pop_strobe && pop_sel == CRS_SEL_PCH) begin
            pc_reg[15:8] <= i_mem_rdata;
        end else if (start_push && i_stack_op == CRS_OP_CALL) begin
            pc_reg <= i_call_target;
        end else if (i_pc_load) begin
            pc_reg <= i_pc_val;
        end else if (i_pc_inc) begin
            pc_reg <= pc_reg + 16'h0001;
        end
    end

    // condition code: pop wins, then load, then mask events and flag updates
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cc_reg <= `CRS_CC_RESET;
        end else if (pop_strobe && pop_sel == CRS_SEL_CC) begin
            cc_reg <= i_mem_rdata;
        end else if (i_load && i_load_sel == CRS_SEL_CC) begin
            cc_reg <= i_load_val;
        end else begin
            if (state_reg == CRS_ST_PUSH && is_int_reg && cnt_reg == len_reg - 3'h1) begin
                cc_reg[`CRS_CC_I_BIT] <= 1'b1;
            end else if (i_mask_set) begin
                cc_reg[`CRS_CC_I_BIT] <= 1'b1;
            end else if (i_unmask) begin
                cc_reg[`CRS_CC_I_BIT] <= 1'b0;
            end
            if (i_alu.valid && i_alu.upd_h) begin
                cc_reg[`CRS_CC_H_BIT] <= i_alu.half;
            end
            if (i_alu.valid && i_alu.upd_nz) begin
                cc_reg[`CRS_CC_N_BIT] <= i_alu.result[7];
                cc_reg[`CRS_CC_Z_BIT] <= (i_alu.result == 8'h00);
            end
            if (i_carry_set) begin
                cc_reg[`CRS_CC_C_BIT] <= 1'b1;
            end else if (i_carry_clear) begin
                cc_reg[`CRS_CC_C_BIT] <= 1'b0;
            end else if (i_alu.valid && i_alu.upd_c) begin
                cc_reg[`CRS_CC_C_BIT] <= i_alu.carry;
            end
        end
    end

    // pending latch; a new request beats the take in the same cycle
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pend_reg <= 1'b0;
        end else if (i_irq) begin
            pend_reg <= 1'b1;
        end else if (take_irq && !i_trap) begin
            pend_reg <= 1'b0;
        end
    end

    // register views
    assign o_accumulator     = acc_reg;
    assign o_index_x         = x_reg;
    assign o_index_y         = y_reg;
    assign o_program_counter = pc_reg;
    assign o_condition_code  = cc_reg;
    assign o_stack_pointer   = sp;
    assign o_busy            = (state_reg != CRS_ST_IDLE);
    assign o_irq_take        = take_irq;
    assign o_irq_pending     = pend_reg;
endmodule // crs_register_set

// ### sim/crs_register_set_properties.sv
// concurrent checks on the register set ports
`timescale 1ns/1ps
module crs_register_set_properties
    import crs_pkg::*;
(
    // clock and reset
    input wire logic          i_clk,
    input wire logic          i_sys_rst,
    // watched inputs
    input wire crs_alu_res_t  i_alu,
    input wire logic          i_load,
    input wire logic          i_carry_set,
    input wire logic          i_carry_clear,
    input wire logic          i_sp_reset,
    input wire crs_stack_op_t i_stack_op,
    input wire logic          i_irq,
    input wire logic          i_trap,
    // watched outputs
    input wire logic [7:0]    o_condition_code,
    input wire logic [15:0]   o_stack_pointer,
    input wire crs_mem_req_t  o_mem,
    input wire logic          o_busy,
    input wire logic          o_irq_take,
    input wire logic          o_irq_pending
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    // pointer field and memory port
    a_sp_hi_fixed: assert property (o_stack_pointer[15:7] == 9'h003)
        else $error("stack pointer upper bits moved");
    a_push_dec: assert property (o_mem.wr |=> o_stack_pointer[6:0] == $past(o_stack_pointer[6:0]) - 7'h01)
        else $error("pointer not decremented");
    a_pop_inc: assert property (o_mem.rd |-> o_stack_pointer[6:0] == $past(o_stack_pointer[6:0]) + 7'h01)
        else $error("pointer not incremented");
    a_entry_at_sp: assert property (o_irq_take |=> o_mem.wr && o_mem.addr == $past(o_stack_pointer))
        else $error("entry write away from pointer");
    a_sp_to_top: assert property (i_sp_reset && !o_busy && i_stack_op == CRS_OP_NONE && !i_load
        |=> o_stack_pointer == 16'h01ff)
        else $error("stack reset missed top");
    // interrupt acceptance
    a_mask_blocks: assert property (o_irq_take |-> !o_condition_code[3] || i_trap)
        else $error("request taken while masked");
    a_int_five: assert property (o_irq_take |=> o_mem.wr [*5] ##1 !o_mem.wr)
        else $error("interrupt frame not five bytes");
    a_entry_mask: assert property (o_irq_take |-> ##[1:7] o_condition_code[3])
        else $error("mask not set on entry");
    a_pend_latch: assert property (i_irq && o_condition_code[3] && !i_trap |=> o_irq_pending)
        else $error("masked request lost");
    a_pend_taken: assert property (o_irq_pending && !o_condition_code[3] && !o_busy
        && i_stack_op == CRS_OP_NONE |-> o_irq_take)
        else $error("pending request not taken");
    // flags follow the alu and the carry set strobe
    a_nz_follow: assert property (i_alu.valid && i_alu.upd_nz |=> o_condition_code[2] == $past(i_alu.result[7])
        && o_condition_code[1] == ($past(i_alu.result) == 8'h00))
        else $error("sign or zero flag wrong");
    a_half_follow: assert property (i_alu.valid && i_alu.upd_h |=> o_condition_code[4] == $past(i_alu.half))
        else $error("half carry wrong");
    a_carry_force: assert property (i_carry_set && !i_carry_clear |=> o_condition_code[0])
        else $error("carry not set");
    c_take: cover property (o_irq_take);
    c_pop: cover property (o_mem.rd);
    c_call: cover property (i_stack_op == CRS_OP_CALL && !o_busy);
endmodule // crs_register_set_properties
bind crs_register_set crs_register_set_properties i_crs_register_set_properties (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_alu(i_alu), .i_load(i_load), .i_carry_set(i_carry_set),
    .i_carry_clear(i_carry_clear), .i_sp_reset(i_sp_reset), .i_stack_op(i_stack_op), .i_irq(i_irq),
    .i_trap(i_trap), .o_condition_code(o_condition_code), .o_stack_pointer(o_stack_pointer), .o_mem(o_mem),
    .o_busy(o_busy), .o_irq_take(o_irq_take), .o_irq_pending(o_irq_pending));

// ### sim/crs_stack_mem_model.sv
// stack ram answering the register set memory port
`timescale 1ns/1ps
module crs_stack_mem_model
    import crs_pkg::*;
(
    input  wire logic         i_clk,
    input  wire crs_mem_req_t i_mem,
    output logic [7:0]        o_rdata
);
    logic [7:0] mem [0:127];
    logic [7:0] last_q = 8'h5a;
    // only 128 bytes, the fixed upper pointer bits select nothing here
    initial begin
        for (int k = 0; k < 128; k++) begin
            mem[k] = 8'h00;
        end
    end
    always @(posedge i_clk) begin
        if (i_mem.wr) begin
            mem[i_mem.addr[6:0]] <= i_mem.wdata;
        end
        if (i_mem.rd) begin
            last_q <= o_rdata;
        end
    end
    // outside a read the bus flips so stale data cannot pass as good
    assign o_rdata = i_mem.rd ? mem[i_mem.addr[6:0]] : ~last_q;
endmodule // crs_stack_mem_model

// ### sim/crs_register_set_tb.sv
// self-checking bench for the cpu register set and stack
`timescale 1ns/1ps
module crs_register_set_tb;
    import crs_pkg::*;
    logic i_clk = 1'b0, i_sys_rst = 1'b1, i_load = 1'b0, i_pc_load = 1'b0, i_pc_inc = 1'b0;
    logic i_mask_set = 1'b0, i_unmask = 1'b0, i_carry_set = 1'b0, i_carry_clear = 1'b0;
    logic i_sp_reset = 1'b0, i_irq = 1'b0, i_trap = 1'b0;
    logic [7:0] i_load_val = 8'h00, i_mem_rdata, o_accumulator, o_index_x, o_index_y, o_condition_code;
    logic [15:0] i_pc_val = 16'h0000, i_call_target = 16'h0000, o_program_counter, o_stack_pointer;
    crs_alu_res_t i_alu = '0;
    crs_sel_t i_load_sel = CRS_SEL_A, i_stack_sel = CRS_SEL_A;
    crs_stack_op_t i_stack_op = CRS_OP_NONE;
    crs_mem_req_t o_mem;
    logic o_busy, o_irq_take, o_irq_pending;
    logic [31:0] seed = 32'h1bf9, r;
    int miscompares, total_checks, cycles, m_a, m_x, m_y, m_pc, m_cc = 'he8, m_sp = 127;
    int m_mem [128];
    crs_register_set i_crs_register_set (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_alu(i_alu), .i_load(i_load),
        .i_load_sel(i_load_sel), .i_load_val(i_load_val), .i_pc_load(i_pc_load), .i_pc_val(i_pc_val),
        .i_pc_inc(i_pc_inc), .i_mask_set(i_mask_set), .i_unmask(i_unmask), .i_carry_set(i_carry_set),
        .i_carry_clear(i_carry_clear), .i_sp_reset(i_sp_reset), .i_stack_op(i_stack_op),
        .i_stack_sel(i_stack_sel), .i_call_target(i_call_target), .i_mem_rdata(i_mem_rdata), .i_irq(i_irq),
        .i_trap(i_trap), .o_accumulator(o_accumulator), .o_index_x(o_index_x), .o_index_y(o_index_y),
        .o_program_counter(o_program_counter), .o_condition_code(o_condition_code),
        .o_stack_pointer(o_stack_pointer), .o_mem(o_mem), .o_busy(o_busy), .o_irq_take(o_irq_take),
        .o_irq_pending(o_irq_pending));
    crs_stack_mem_model i_crs_stack_mem_model (.i_clk(i_clk), .i_mem(o_mem), .o_rdata(i_mem_rdata));
    initial begin
        forever #50 i_clk = ~i_clk;
    end
    // hang guard, run needs under a thousand cycles
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            $display("BAD %0t timeout", $time);
            stop_test();
        end
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_all(input logic [7:0] ccm);
        @(negedge i_clk);
        chk(o_accumulator, m_a[7:0]);
        chk(o_index_x, m_x[7:0]);
        chk(o_index_y, m_y[7:0]);
        chk(o_condition_code & ccm, m_cc[7:0] & ccm);
        chk(o_stack_pointer, 16'h0180 | m_sp[6:0]);
    endtask
    // bytes just above the pointer
    task automatic chk_stack(input int n);
        int idx;
        for (int k = 1; k <= n; k++) begin
            idx = (m_sp + k) & 127;
            chk(i_crs_stack_mem_model.mem[idx], m_mem[idx][7:0]);
        end
    endtask
    task automatic strobe(input int k);
        @(posedge i_clk);
        {i_mask_set, i_unmask, i_carry_set, i_carry_clear, i_sp_reset, i_pc_inc, i_irq, i_trap} <= 8'h80 >> k;
        @(posedge i_clk);
        {i_mask_set, i_unmask, i_carry_set, i_carry_clear, i_sp_reset, i_pc_inc, i_irq, i_trap} <= 8'h00;
    endtask
    task automatic wait_idle();
        repeat (2) @(negedge i_clk);
        for (int n = 0; n < 40 && o_busy !== 1'b0; n++) begin
            @(negedge i_clk);
        end
    endtask
    task automatic ld(input int s, input logic [7:0] v);
        @(posedge i_clk);
        i_load <= 1'b1;
        i_load_sel <= crs_sel_t'(s);
        i_load_val <= v;
        @(posedge i_clk);
        i_load <= 1'b0;
        case (s)
            0: m_a = v;
            1: m_x = v;
            2: m_y = v;
            3: m_cc = v;
            default: m_sp = v[6:0];
        endcase
    endtask
    task automatic op(input crs_stack_op_t o, input int s, input logic [15:0] t);
        @(posedge i_clk);
        i_stack_op <= o;
        i_stack_sel <= crs_sel_t'(s);
        i_call_target <= t;
        @(posedge i_clk);
        i_stack_op <= CRS_OP_NONE;
        wait_idle();
    endtask
    task automatic alu_op(input logic [7:0] res, input logic h, input logic c);
        @(posedge i_clk);
        i_alu <= {1'b1, res, 1'b1, h, 1'b1, c, 2'b11};
        @(posedge i_clk);
        i_alu <= '0;
        m_a = res;
        m_cc = {m_cc[7:5], h, m_cc[3], res[7], res == 8'h00, c};
    endtask
    // entry via unmask (1), trap (7) or int op (8); frame is pcl, pch, x, a, cc downward
    task automatic take_int(input int k);
        int s0;
        s0 = m_sp;
        if (k > 7) begin
            op(CRS_OP_INT, 0, 16'h0000);
        end else begin
            strobe(k);
        end
        wait_idle();
        m_mem[s0] = m_pc & 255;
        m_mem[(s0 - 1) & 127] = m_pc >> 8;
        m_mem[(s0 - 2) & 127] = m_x;
        m_mem[(s0 - 3) & 127] = m_a;
        m_mem[(s0 - 4) & 127] = m_cc;
        m_sp = (s0 - 5) & 127;
        m_cc[3] = 1'b1;
        check_all(8'hff);
        chk_stack(5);
        ld(0, rnd());
        ld(1, rnd());
        op(CRS_OP_INTERRUPT_RETURN_INSTR, 0, 16'h0000);
        m_sp = s0;
        m_a = m_mem[(s0 - 3) & 127];
        m_x = m_mem[(s0 - 2) & 127];
        m_cc = m_mem[(s0 - 4) & 127];
        check_all(8'hff);
        chk(o_program_counter, m_pc[15:0]);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        check_all(8'hff);
        chk(o_program_counter, 16'h0000);
        for (int s = 0; s < 3; s++) begin
            ld(s, rnd());
        end
        check_all(8'hff);
        for (int i = 0; i < 12; i++) begin
            r = rnd();
            alu_op((i == 0) ? 8'h00 : r[7:0], r[8], r[9]);
            check_all(8'hff);
        end
        strobe(2);
        m_cc[0] = 1'b1;
        check_all(8'hff);
        strobe(3);
        m_cc[0] = 1'b0;
        check_all(8'hff);
        ld(4, 8'h81);
        check_all(8'hff);
        // three pushes from 01 cross the lower limit
        for (int i = 0; i < 3; i++) begin
            op(CRS_OP_PUSH_BYTE, i, 16'h0000);
            m_mem[m_sp] = (i == 0) ? m_a : (i == 1) ? m_x : m_y;
            m_sp = (m_sp - 1) & 127;
        end
        check_all(8'hff);
        chk_stack(3);
        for (int i = 0; i < 3; i++) begin
            op(CRS_OP_POP_BYTE, i, 16'h0000);
            m_sp = (m_sp + 1) & 127;
            if (i == 0) m_a = m_mem[m_sp];
            else if (i == 1) m_x = m_mem[m_sp];
            else m_y = m_mem[m_sp];
        end
        check_all(8'hff);
        strobe(4);
        m_sp = 127;
        check_all(8'hff);
        r = rnd();
        @(posedge i_clk);
        i_pc_load <= 1'b1;
        i_pc_val <= r[15:0];
        @(posedge i_clk);
        i_pc_load <= 1'b0;
        strobe(5);
        m_pc = (r[15:0] + 1) & 65535;
        check_all(8'hff);
        chk(o_program_counter, m_pc[15:0]);
        r = rnd();
        op(CRS_OP_CALL, 0, r[15:0]);
        m_mem[m_sp] = m_pc & 255;
        m_mem[(m_sp - 1) & 127] = m_pc >> 8;
        m_sp = (m_sp - 2) & 127;
        check_all(8'hff);
        chk(o_program_counter, r[15:0]);
        chk_stack(2);
        op(CRS_OP_RET, 0, 16'h0000);
        m_sp = (m_sp + 2) & 127;
        check_all(8'hff);
        chk(o_program_counter, m_pc[15:0]);
        // masked request waits, then unmask lets it in
        strobe(6);
        check_all(8'hff);
        chk(o_irq_pending, 16'h0001);
        m_cc[3] = 1'b0;
        take_int(1);
        chk(o_irq_pending, 16'h0000);
        strobe(0);
        m_cc[3] = 1'b1;
        check_all(8'hff);
        take_int(7);
        ld(3, rnd());
        take_int(8);
        stop_test();
    end
endmodule // crs_register_set_tb
